// >>> shared/holdover_pkg.sv
// Shared constants and types for the holdover frequency control registers
package holdover_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  OFFSET_MID      = 8'h3f;
  localparam logic [7:0]  OFFSET_MODES    = 8'h40;
  localparam logic [7:0]  RESET_MID       = 8'h00;
  localparam logic [7:0]  RESET_MODES     = 8'h88;
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

  // ****************************************************************
  // Field positions in the modes register
  // ****************************************************************
  localparam int          BIT_AUTO_AVG    = 7;
  localparam int          BIT_FAST_AVG    = 6;
  localparam int          BIT_READ_AVG    = 5;
  localparam int          MINI_MSB        = 4;
  localparam int          MINI_LSB        = 3;
  localparam int          TOP_MSB         = 2;
  localparam int          TOP_LSB         = 0;

  // ****************************************************************
  // Frequency word layout
  // ****************************************************************
  localparam int          FREQ_W          = 19;
  localparam logic [18:0] FREQ_ZERO       = 19'h0_0000;

  // Holdover source in use
  typedef enum logic [2:0] {
    SRC_AVERAGED = 3'h1,
    SRC_MANUAL   = 3'h2,
    SRC_FROZEN   = 3'h4
  } hold_src_t;

  // Decoded modes register
  typedef struct packed {
    logic       auto_avg;
    logic       fast_avg;
    logic       read_avg;
    logic [1:0] mini_mode;
  } hold_cfg_t;

  localparam hold_cfg_t   CFG_RESET       = '{auto_avg: 1'b1, fast_avg: 1'b0,
                                              read_avg: 1'b0, mini_mode: 2'h1};

endpackage

// >>> hdl/hold_freq_select.sv
// Holdover frequency source selection with frozen instantaneous capture
`timescale 1ns/1ps
module hold_freq_select (
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           rst,
  // Configuration
  input  wire holdover_pkg::hold_cfg_t        cfg,
  input  wire logic [holdover_pkg::FREQ_W-1:0] manual_word,
  input  wire logic                           manual_engaged,
  // Loop status
  input  wire logic [holdover_pkg::FREQ_W-1:0] live_freq,
  input  wire logic [holdover_pkg::FREQ_W-1:0] avg_freq,
  input  wire logic                           holdover_active,
  // Result
  output logic [holdover_pkg::FREQ_W-1:0]      holdover_freq,
  output holdover_pkg::hold_src_t             holdover_src
);

  logic [holdover_pkg::FREQ_W-1:0] frozen_reg;
  holdover_pkg::hold_src_t         src_next;
  logic [holdover_pkg::FREQ_W-1:0] freq_next;

  // Freeze tracks the live loop until holdover begins, then stops
  always_ff @(posedge mclk) begin
    if (rst) begin
      frozen_reg <= holdover_pkg::FREQ_ZERO;
    end else if (!holdover_active) begin
      frozen_reg <= live_freq;
    end
  end

  // Manual wins over averaging; otherwise averaged or frozen
  assign src_next  = manual_engaged ? holdover_pkg::SRC_MANUAL :
                     cfg.auto_avg   ? holdover_pkg::SRC_AVERAGED :
                                      holdover_pkg::SRC_FROZEN;
  assign freq_next = (src_next == holdover_pkg::SRC_MANUAL)   ? manual_word :
                     (src_next == holdover_pkg::SRC_AVERAGED) ? avg_freq : frozen_reg;

  // Registered result
  always_ff @(posedge mclk) begin
    if (rst) begin
      holdover_freq <= holdover_pkg::FREQ_ZERO;
      holdover_src  <= holdover_pkg::SRC_AVERAGED;
    end else begin
      holdover_freq <= freq_next;
      holdover_src  <= src_next;
    end
  end

  chk_avg_when_auto: assert property (@(posedge mclk) disable iff (rst)
    (cfg.auto_avg && !manual_engaged) |=> (holdover_src == holdover_pkg::SRC_AVERAGED))
    else $error("averaged source not chosen");
  chk_manual_wins: assert property (@(posedge mclk) disable iff (rst)
    manual_engaged |=> (holdover_freq == $past(manual_word)))
    else $error("manual word not used when engaged");
  // Needs two settled cycles of frozen selection; a mode change just before
  // the window legally moves the result once.
  chk_frozen_held: assert property (@(posedge mclk) disable iff (rst)
    (!cfg.auto_avg && $stable(cfg.auto_avg) && !manual_engaged && !$past(manual_engaged) &&
     holdover_active && $past(holdover_active)) |=> (holdover_freq == $past(holdover_freq)))
    else $error("frozen frequency moved during holdover");

endmodule

// >>> hdl/holdover_frequency_control.sv
// Manual holdover frequency and holdover modes registers of the main timing loop
//
// How it works
// - Middle byte register, read/write, resets zero
// - Manual word matches live loop frequency format
// - Modes register resets 0x88, fields packed
// - Averaged, manual or frozen frequency in holdover
`timescale 1ns/1ps
module holdover_frequency_control (
  // Clock and reset
  input  wire logic                                 mclk,
  input  wire logic                                 rst,
  // Microprocessor register port
  input  wire logic [holdover_pkg::ADDR_W-1:0]      bus_addr,
  input  wire logic                                 bus_wr,
  input  wire logic                                 bus_rd,
  input  wire logic [holdover_pkg::DATA_W-1:0]      bus_wdata,
  output logic [holdover_pkg::DATA_W-1:0]           bus_rdata,
  output logic                                      bus_rvalid,
  // Low byte of the manual word, held in a neighbouring register
  input  wire logic [7:0]                           manual_hold_offset_low,
  // Loop status
  input  wire logic [holdover_pkg::FREQ_W-1:0]      live_loop_frequency_status,
  input  wire logic [holdover_pkg::FREQ_W-1:0]      avg_freq,
  input  wire logic                                 holdover_active,
  input  wire logic                                 manual_engaged,
  // Configuration to the main timing loop
  output holdover_pkg::hold_cfg_t                   hold_cfg,
  output logic [holdover_pkg::FREQ_W-1:0]           manual_word,
  output logic [holdover_pkg::FREQ_W-1:0]           holdover_freq,
  output holdover_pkg::hold_src_t                   holdover_src
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] manual_hold_offset_mid_reg;
  logic [7:0] holdover_behaviour_control_reg;
  logic [7:0] rdata_next;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic hit_mid;
  logic hit_modes;
  logic wr_mid;
  logic wr_modes;
  logic read_avg;

  // Top three bits of the frequency word, kept in the modes register
  function automatic logic [2:0] top_field(input logic [7:0] modes);
    return modes[holdover_pkg::TOP_MSB:holdover_pkg::TOP_LSB];
  endfunction

  assign hit_mid   = (bus_addr == holdover_pkg::OFFSET_MID);
  assign hit_modes = (bus_addr == holdover_pkg::OFFSET_MODES);
  assign wr_mid    = bus_wr && hit_mid;
  assign wr_modes  = bus_wr && hit_modes;
  assign read_avg  = holdover_behaviour_control_reg[holdover_pkg::BIT_READ_AVG];

  // Middle byte register
  always_ff @(posedge mclk) begin
    if (rst) begin
      manual_hold_offset_mid_reg <= holdover_pkg::RESET_MID;
    end else if (wr_mid) begin
      manual_hold_offset_mid_reg <= bus_wdata;
    end
  end

  // Modes register
  always_ff @(posedge mclk) begin
    if (rst) begin
      holdover_behaviour_control_reg <= holdover_pkg::RESET_MODES;
    end else if (wr_modes) begin
      holdover_behaviour_control_reg <= bus_wdata;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // With read-average set, the frequency fields show the averager so that
  // software can watch it; the stored values stay untouched underneath.
  logic [7:0] mid_view;
  logic [2:0] top_view;

  assign mid_view   = read_avg ? avg_freq[15:8] : manual_hold_offset_mid_reg;
  assign top_view   = read_avg ? avg_freq[18:16] : top_field(holdover_behaviour_control_reg);
  assign rdata_next = hit_mid   ? mid_view :
                      hit_modes ? {holdover_behaviour_control_reg[7:3], top_view} :
                                  holdover_pkg::READ_UNMAPPED;

  // Read data lands one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_rdata  <= holdover_pkg::READ_UNMAPPED;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_rd;
      if (bus_rd) begin
        bus_rdata <= rdata_next;
      end
    end
  end

  // ****************************************************************
  // Configuration outputs
  // ****************************************************************
  // Same 19-bit signed layout as the live loop frequency, so a filtered
  // readback can be written back byte for byte.
  logic [holdover_pkg::FREQ_W-1:0] word_next;
  holdover_pkg::hold_cfg_t         cfg_next;

  assign word_next = {top_field(holdover_behaviour_control_reg),
                      manual_hold_offset_mid_reg, manual_hold_offset_low};
  assign cfg_next  = '{auto_avg:  holdover_behaviour_control_reg[holdover_pkg::BIT_AUTO_AVG],
                       fast_avg:  holdover_behaviour_control_reg[holdover_pkg::BIT_FAST_AVG],
                       read_avg:  read_avg,
                       mini_mode: holdover_behaviour_control_reg[holdover_pkg::MINI_MSB:
                                                                 holdover_pkg::MINI_LSB]};

  // Registered copies for the loop
  always_ff @(posedge mclk) begin
    if (rst) begin
      manual_word <= holdover_pkg::FREQ_ZERO;
      hold_cfg    <= holdover_pkg::CFG_RESET;
    end else begin
      manual_word <= word_next;
      hold_cfg    <= cfg_next;
    end
  end

  // ****************************************************************
  // Holdover source selection
  // ****************************************************************
  hold_freq_select u_select (
    .mclk            (mclk),
    .rst             (rst),
    .cfg             (hold_cfg),
    .manual_word     (manual_word),
    .manual_engaged  (manual_engaged),
    .live_freq       (live_loop_frequency_status),
    .avg_freq        (avg_freq),
    .holdover_active (holdover_active),
    .holdover_freq   (holdover_freq),
    .holdover_src    (holdover_src)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_mid_write_read: assert property (@(posedge mclk) disable iff (rst)
    (wr_mid && !read_avg) ##1 (bus_rd && hit_mid && !bus_wr && !read_avg)
      |=> (bus_rvalid && bus_rdata == $past(bus_wdata, 2)))
    else $error("middle byte readback differs from write");
  chk_mid_reset: assert property (@(posedge mclk)
    $past(rst) |-> (manual_hold_offset_mid_reg == holdover_pkg::RESET_MID))
    else $error("middle byte not cleared by reset");
  chk_modes_reset: assert property (@(posedge mclk)
    $past(rst) |-> (holdover_behaviour_control_reg == holdover_pkg::RESET_MODES))
    else $error("modes register reset value wrong");
  chk_cfg_follows: assert property (@(posedge mclk) disable iff (rst)
    wr_modes |=> ##1 (hold_cfg.auto_avg == $past(bus_wdata[7], 2) &&
                      hold_cfg.mini_mode == $past(bus_wdata[4:3], 2)))
    else $error("modes fields not delivered");
  chk_word_layout: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |-> (manual_word == {$past(holdover_behaviour_control_reg[2:0]),
                                     $past(manual_hold_offset_mid_reg),
                                     $past(manual_hold_offset_low)}))
    else $error("manual word assembled wrongly");
  chk_unmapped_zero: assert property (@(posedge mclk) disable iff (rst)
    (bus_rd && !hit_mid && !hit_modes) |=> (bus_rdata == holdover_pkg::READ_UNMAPPED))
    else $error("unmapped read not zero");

  // Read strobe and answer pair up; software polls nothing, so no slip
  chk_rvalid_pulse: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |-> (bus_rvalid == $past(bus_rd)))
    else $error("read answer not one cycle after strobe");
  chk_rdata_holds: assert property (@(posedge mclk) disable iff (rst)
    !bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");

  // Stored bytes change only on their own write strobe
  chk_mid_no_stray: assert property (@(posedge mclk) disable iff (rst)
    !wr_mid |=> $stable(manual_hold_offset_mid_reg))
    else $error("middle byte changed without a write");
  chk_modes_no_stray: assert property (@(posedge mclk) disable iff (rst)
    !wr_modes |=> $stable(holdover_behaviour_control_reg))
    else $error("modes register changed without a write");

  // Modes readback and delivery of the remaining fields
  chk_modes_write_read: assert property (@(posedge mclk) disable iff (rst)
    (wr_modes && !bus_wdata[holdover_pkg::BIT_READ_AVG]) ##1 (bus_rd && hit_modes && !bus_wr)
      |=> (bus_rvalid && bus_rdata == $past(bus_wdata, 2)))
    else $error("modes readback differs from write");
  chk_cfg_fields: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |->
      (hold_cfg.fast_avg == $past(holdover_behaviour_control_reg[holdover_pkg::BIT_FAST_AVG]) &&
       hold_cfg.read_avg == $past(holdover_behaviour_control_reg[holdover_pkg::BIT_READ_AVG])))
    else $error("fast or read-average field not delivered");

  // Read-average swaps only the frequency fields of the readback; the
  // control bits of the modes byte always come from storage.
  chk_avg_mid_view: assert property (@(posedge mclk) disable iff (rst)
    (bus_rd && hit_mid && read_avg) |=> (bus_rdata == $past(avg_freq[15:8])))
    else $error("middle byte readback not averaged value");
  chk_avg_top_view: assert property (@(posedge mclk) disable iff (rst)
    (bus_rd && hit_modes && read_avg)
      |=> (bus_rdata == {$past(holdover_behaviour_control_reg[7:3]), $past(avg_freq[18:16])}))
    else $error("modes readback not averaged top bits");

endmodule

// >>> tb/holdover_frequency_control_tb.sv
// Self-checking bench for the holdover frequency control registers
`timescale 1ns/1ps
module holdover_frequency_control_tb;
  logic                    mclk = 1'b0;
  logic                    rst = 1'b1;
  logic [7:0]              bus_addr = 8'h00;
  logic                    bus_wr = 1'b0;
  logic                    bus_rd = 1'b0;
  logic [7:0]              bus_wdata = 8'h00;
  logic [7:0]              bus_rdata;
  logic                    bus_rvalid;
  logic [7:0]              low_byte = 8'h5a;
  logic [18:0]             live_freq = 19'h2_0f0f;
  logic [18:0]             avg_freq = 19'h4_1234;
  logic                    hold_on = 1'b0;
  logic                    man_on = 1'b0;
  holdover_pkg::hold_cfg_t hold_cfg;
  logic [18:0]             manual_word;
  logic [18:0]             holdover_freq;
  holdover_pkg::hold_src_t holdover_src;
  int                      num_errors = 0;
  int                      n_tests = 0;

  holdover_frequency_control dut_u (
    .mclk                       (mclk),
    .rst                        (rst),
    .bus_addr                   (bus_addr),
    .bus_wr                     (bus_wr),
    .bus_rd                     (bus_rd),
    .bus_wdata                  (bus_wdata),
    .bus_rdata                  (bus_rdata),
    .bus_rvalid                 (bus_rvalid),
    .manual_hold_offset_low     (low_byte),
    .live_loop_frequency_status (live_freq),
    .avg_freq                   (avg_freq),
    .holdover_active            (hold_on),
    .manual_engaged             (man_on),
    .hold_cfg                   (hold_cfg),
    .manual_word                (manual_word),
    .holdover_freq              (holdover_freq),
    .holdover_src               (holdover_src)
  );

  // 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic check(input string name, input logic [18:0] seen, input logic [18:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Strobes rise and fall at falling edges, one pulse per access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge mclk);
    bus_wr = 1'b0;
  endtask

  // Answer must stand exactly one cycle after the strobe, then drop
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge mclk);
    bus_rd = 1'b0;
    check("rvalid", {18'h0, bus_rvalid}, 19'h1);
    check("rdata", {11'h0, bus_rdata}, {11'h0, exp});
    @(negedge mclk);
    check("rvalid_low", {18'h0, bus_rvalid}, 19'h0);
  endtask

  // Write, then read the same place on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge mclk);
    bus_wr = 1'b0;
    bus_rd = 1'b1;
    @(negedge mclk);
    bus_rd = 1'b0;
    check("wr_rd_valid", {18'h0, bus_rvalid}, 19'h1);
    check("wr_rd_data", {11'h0, bus_rdata}, {11'h0, d});
  endtask

  task automatic settle();
    repeat (3) @(negedge mclk);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the 67 cycles the tests need
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    rd(holdover_pkg::OFFSET_MID, 8'h00);
    rd(holdover_pkg::OFFSET_MODES, 8'h88);
    check("cfg", {14'h0, hold_cfg}, {14'h0, holdover_pkg::CFG_RESET});
    check("src", {16'h0, holdover_src}, {16'h0, holdover_pkg::SRC_AVERAGED});
    check("hfreq", holdover_freq, avg_freq);
    // Negative word, then read back; unmapped place ignored
    wr_rd(holdover_pkg::OFFSET_MID, 8'ha5);
    wr_rd(holdover_pkg::OFFSET_MODES, 8'h07);
    wr(8'h41, 8'hff);
    rd(holdover_pkg::OFFSET_MID, 8'ha5);
    rd(holdover_pkg::OFFSET_MODES, 8'h07);
    rd(8'h41, 8'h00);
    settle();
    check("mword", manual_word, 19'h7_a55a);
    check("cfg", {14'h0, hold_cfg}, 19'h0);
    // Averaging off: frozen tracks live, then holds in holdover
    check("src", {16'h0, holdover_src}, {16'h0, holdover_pkg::SRC_FROZEN});
    check("hfreq", holdover_freq, 19'h2_0f0f);
    hold_on = 1'b1;
    @(negedge mclk);
    live_freq = 19'h6_0001;
    settle();
    check("hfreq", holdover_freq, 19'h2_0f0f);
    man_on = 1'b1;
    settle();
    check("src", {16'h0, holdover_src}, {16'h0, holdover_pkg::SRC_MANUAL});
    check("hfreq", holdover_freq, 19'h7_a55a);
    // Averaging on but manual engaged still wins
    wr(holdover_pkg::OFFSET_MODES, 8'h88);
    settle();
    check("src", {16'h0, holdover_src}, {16'h0, holdover_pkg::SRC_MANUAL});
    man_on = 1'b0;
    settle();
    check("src", {16'h0, holdover_src}, {16'h0, holdover_pkg::SRC_AVERAGED});
    check("hfreq", holdover_freq, 19'h4_1234);
    // Read-average shows averaged value, stored word untouched
    wr(holdover_pkg::OFFSET_MODES, 8'h79);
    rd(holdover_pkg::OFFSET_MID, 8'h12);
    rd(holdover_pkg::OFFSET_MODES, 8'h7c);
    settle();
    check("cfg", {14'h0, hold_cfg}, 19'h0f);
    check("mword", manual_word, 19'h1_a55a);
    // Reset in mid-run restores defaults
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    rd(holdover_pkg::OFFSET_MID, 8'h00);
    rd(holdover_pkg::OFFSET_MODES, 8'h88);
    stop_test();
  end
endmodule
